/* verilog/adcrw_regs.sv */
// AHB-Lite register file, accumulator, flags and converter clock of the result block.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "adcrw_map.svh"
// How it works
// - One 8-bit latch serves every 16-bit register for atomic access.
// - The latch is itself a readable, writable byte register, reset zero.
// - Result is a read-only byte pair, low at base, high at base plus one.
// - Inputs above reference saturate at the 10-bit maximum code.
// - Inputs below ground clamp to code zero.
// - Up to 64 samples accumulate; the sum never exceeds 0xffc0.
// - Result bit 15 is the most significant; converter code MSB is bit 9.
// - Result and thresholds are unsigned magnitudes compared unsigned.
// - Low threshold is a read/write byte pair feeding the comparator, reset zero.
// - High threshold is a read/write byte pair feeding the comparator, reset zero.
// - The comparator judges only the final accumulated value.
// - Duty bit one gives 25 percent high clock, zero gives 50 percent.
// - Mode field selects none, below, above, strictly inside or outside.
// - Ready and window flags clear by writing one or reading the result.
module adcrw_regs (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_b,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Conversion engine, same clock.
   input wire logic sample_valid,
   input wire logic signed [11:0] sample_raw,
   // Converter clock and interrupt.
   output logic adc_clk,
   output logic irq
);
   adcrw_win_if win ();

   adcrw_pkg::adcrw_state_t state;
   adcrw_pkg::adcrw_state_t next_state;
   logic wr_pend;
   logic [7:0] wr_idx;
   logic [7:0] rd_idx;
   logic [7:0] ctrl;
   logic [7:0] mask;
   logic [1:0] flags;
   logic [7:0] byte_latch;
   logic [15:0] conversion_result;
   logic [15:0] window_low_threshold;
   logic [15:0] window_high_threshold;
   logic [7:0] clock_duty_calibration;
   logic [15:0] acc;
   logic [5:0] cnt;
   logic [1:0] phase;
   logic [7:0] rd_byte;
   logic [7:0] next_latch;

   // Only word transfers are expected, so the size is not decoded.
   wire unused_size = |hsize;
   wire take = hsel && htrans[1] && hready;
   wire [7:0] addr_idx = haddr[9:2];
   wire addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00);
   wire rd_fire = (state == adcrw_pkg::ADCRW_ST_READ);
   wire [7:0] wdata = hwdata[7:0];

   function automatic logic wr_hit(input logic [7:0] target);
      wr_hit = wr_pend && (wr_idx == target);
   endfunction

   function automatic logic rd_hit(input logic [7:0] target);
      rd_hit = rd_fire && (rd_idx == target);
   endfunction

   wire w_ctrl = wr_hit(`ADCRW_IDX_CTRL);
   wire w_mask = wr_hit(`ADCRW_IDX_MASK);
   wire w_flags = wr_hit(`ADCRW_IDX_FLAGS);
   wire w_latch = wr_hit(`ADCRW_IDX_LATCH);
   wire w_wlt_l = wr_hit(`ADCRW_IDX_WLT_L);
   wire w_wlt_h = wr_hit(`ADCRW_IDX_WLT_H);
   wire w_wht_l = wr_hit(`ADCRW_IDX_WHT_L);
   wire w_wht_h = wr_hit(`ADCRW_IDX_WHT_H);
   wire w_cal = wr_hit(`ADCRW_IDX_CAL);
   wire r_res_l = rd_hit(`ADCRW_IDX_RES_L);
   wire r_wlt_l = rd_hit(`ADCRW_IDX_WLT_L);
   wire r_wht_l = rd_hit(`ADCRW_IDX_WHT_L);

   wire [9:0] code = (sample_raw < 12'sd0) ? 10'h000 :
                     (sample_raw > $signed({2'b00, `ADCRW_CODE_MAX})) ? `ADCRW_CODE_MAX :
                     sample_raw[9:0];

   // At most 64 samples per result.
   wire [2:0] acc_log2 = (ctrl[`ADCRW_ACC_MSB:`ADCRW_ACC_LSB] > `ADCRW_MAX_LOG2) ?
                         `ADCRW_MAX_LOG2 : ctrl[`ADCRW_ACC_MSB:`ADCRW_ACC_LSB];
   wire [6:0] acc_span = 7'h01 << acc_log2;
   wire [5:0] last_cnt = 6'(acc_span - 7'h01);
   wire [15:0] sum = acc + {6'h00, code};
   wire done = sample_valid && (cnt == last_cnt);

   assign win.clk = clk_sys;
   assign win.rst_b = rst_b;
   assign win.value = sum;
   assign win.low = window_low_threshold;
   assign win.high = window_high_threshold;
   assign win.mode = adcrw_pkg::adcrw_mode_t'(ctrl[`ADCRW_MODE_MSB:0]);

   adcrw_window u_window (
      .win (win)
   );

   wire [1:0] flag_set = {done && win.match, done};
   wire [1:0] flag_clr = (w_flags ? wdata[1:0] : 2'b00) | (r_res_l ? 2'b11 : 2'b00);
   wire [1:0] next_flags = (flags & ~flag_clr) | flag_set;
   wire duty_quarter = clock_duty_calibration[`ADCRW_DUTY_BIT];

   always_comb begin
      case (state)
         adcrw_pkg::ADCRW_ST_IDLE: begin
            next_state = (take && !hwrite) ? adcrw_pkg::ADCRW_ST_READ :
                         adcrw_pkg::ADCRW_ST_IDLE;
         end
         default: begin
            next_state = adcrw_pkg::ADCRW_ST_IDLE;
         end
      endcase
   end

   // Low read captures the high half; low write parks the byte.
   always_comb begin
      next_latch = byte_latch;
      if (w_latch || w_wlt_l || w_wht_l) begin
         next_latch = wdata;
      end else if (r_res_l) begin
         next_latch = conversion_result[15:8];
      end else if (r_wlt_l) begin
         next_latch = window_low_threshold[15:8];
      end else if (r_wht_l) begin
         next_latch = window_high_threshold[15:8];
      end
   end

   always_comb begin
      if (rd_idx == `ADCRW_IDX_CTRL) begin
         rd_byte = ctrl;
      end else if (rd_idx == `ADCRW_IDX_MASK) begin
         rd_byte = mask;
      end else if (rd_idx == `ADCRW_IDX_FLAGS) begin
         rd_byte = {6'h00, flags};
      end else if (rd_idx == `ADCRW_IDX_RES_L) begin
         rd_byte = conversion_result[7:0];
      end else if (rd_idx == `ADCRW_IDX_WLT_L) begin
         rd_byte = window_low_threshold[7:0];
      end else if (rd_idx == `ADCRW_IDX_WHT_L) begin
         rd_byte = window_high_threshold[7:0];
      end else if (rd_idx == `ADCRW_IDX_CAL) begin
         rd_byte = clock_duty_calibration;
      end else if (rd_idx == `ADCRW_IDX_LATCH || rd_idx == `ADCRW_IDX_RES_H ||
                   rd_idx == `ADCRW_IDX_WLT_H || rd_idx == `ADCRW_IDX_WHT_H) begin
         rd_byte = byte_latch;
      end else begin
         rd_byte = 8'h00;
      end
   end

   // Reads take one wait state so that a write in its data phase lands first.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state <= adcrw_pkg::ADCRW_ST_IDLE;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         wr_pend <= 1'b0;
         wr_idx <= 8'h00;
         rd_idx <= 8'h00;
      end else begin
         state <= next_state;
         hreadyout <= !(next_state == adcrw_pkg::ADCRW_ST_READ);
         wr_pend <= take && hwrite && addr_ok;
         wr_idx <= addr_idx;
         if (take && !hwrite) begin
            rd_idx <= addr_ok ? addr_idx : 8'hff;
         end
         if (rd_fire) begin
            hrdata <= {24'h00_0000, rd_byte};
         end
      end
   end

   // Low threshold commits as a pair.
   // High threshold commits as a pair.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl <= `ADCRW_RST_BYTE;
         mask <= `ADCRW_RST_BYTE;
         byte_latch <= `ADCRW_RST_BYTE;
         window_low_threshold <= `ADCRW_RST_WORD;
         window_high_threshold <= `ADCRW_RST_WORD;
         clock_duty_calibration <= `ADCRW_RST_CAL;
      end else begin
         byte_latch <= next_latch;
         if (w_ctrl) begin
            ctrl <= wdata;
         end
         if (w_mask) begin
            mask <= {6'h00, wdata[1:0]};
         end
         if (w_wlt_h) begin
            window_low_threshold <= {wdata, byte_latch};
         end
         if (w_wht_h) begin
            window_high_threshold <= {wdata, byte_latch};
         end
         if (w_cal) begin
            clock_duty_calibration <= {7'h00, wdata[`ADCRW_DUTY_BIT]};
         end
      end
   end

   // Sum sits right-aligned, bit 15 most significant.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         acc <= `ADCRW_RST_WORD;
         cnt <= 6'h00;
         conversion_result <= `ADCRW_RST_WORD;
         flags <= 2'b00;
         irq <= 1'b0;
      end else begin
         flags <= next_flags;
         irq <= |(next_flags & mask[1:0]);
         if (done) begin
            conversion_result <= sum;
            acc <= `ADCRW_RST_WORD;
            cnt <= 6'h00;
         end else if (sample_valid) begin
            acc <= sum;
            cnt <= cnt + 6'h01;
         end
      end
   end

   // Quarter or half duty converter clock.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         phase <= 2'h0;
         adc_clk <= 1'b0;
      end else begin
         phase <= phase + 2'h1;
         adc_clk <= duty_quarter ? (phase == 2'h3) : !phase[1];
      end
   end

   chk_read_wait: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (take && !hwrite && hreadyout) |=> !hreadyout ##1 hreadyout)
      else $error("Read did not answer after exactly one wait state.");
   chk_result_ceiling: assert property (@(posedge clk_sys) disable iff (!rst_b)
      conversion_result <= `ADCRW_ACC_CEIL)
      else $error("Accumulated result above its ceiling.");
   chk_result_readonly: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !done |=> $stable(conversion_result))
      else $error("Result changed without a finished accumulation.");
   chk_code_saturate: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (sample_raw > 12'sd1023) |-> (code == `ADCRW_CODE_MAX))
      else $error("Over-range sample not saturated.");
   chk_code_clamp: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (sample_raw < 12'sd0) |-> (code == 10'h000))
      else $error("Negative sample not clamped.");
   chk_low_read_latch: assert property (@(posedge clk_sys) disable iff (!rst_b)
      r_res_l |=> (byte_latch == $past(conversion_result[15:8])))
      else $error("Low result read did not capture the high byte.");
   chk_pair_commit: assert property (@(posedge clk_sys) disable iff (!rst_b)
      w_wlt_h |=> (window_low_threshold == {$past(wdata), $past(byte_latch)}))
      else $error("Low threshold pair did not commit atomically.");
   chk_flag_clear_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (r_res_l && !done) |=> (flags == 2'b00))
      else $error("Result read did not clear both flags.");
   chk_flag_write_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (w_flags && wdata[1:0] == 2'b00 && !done && !r_res_l) |=> (flags == $past(flags)))
      else $error("Writing zero changed a flag.");
   chk_flag_set_wins: assert property (@(posedge clk_sys) disable iff (!rst_b)
      done |=> flags[`ADCRW_FLAG_RDY] ##1 (flags[`ADCRW_FLAG_RDY] || $past(flag_clr[0])))
      else $error("Completion lost its ready flag.");
   chk_duty_quarter: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ($rose(adc_clk) && duty_quarter) ##1 duty_quarter |-> !adc_clk)
      else $error("Quarter duty clock stayed high two cycles.");
   chk_duty_half: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ($rose(adc_clk) && !duty_quarter) ##1 !duty_quarter |-> adc_clk)
      else $error("Half duty clock high only one cycle.");

   cov_window_hit: cover property (@(posedge clk_sys) disable iff (!rst_b) done && win.match);
   cov_result_read: cover property (@(posedge clk_sys) disable iff (!rst_b) r_res_l);
   cov_pair_write: cover property (@(posedge clk_sys) disable iff (!rst_b) w_wlt_l ##[1:4] w_wlt_h);
   cov_irq_rise: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(irq));
endmodule

/* verilog/adcrw_map.svh */
// Register indices, reset values and fixed figures of the converter result block.
`ifndef ADCRW_MAP_SVH
`define ADCRW_MAP_SVH
`define ADCRW_IDX_CTRL 8'h04
`define ADCRW_IDX_MASK 8'h0a
`define ADCRW_IDX_FLAGS 8'h0b
`define ADCRW_IDX_LATCH 8'h0d
`define ADCRW_IDX_RES_L 8'h10
`define ADCRW_IDX_RES_H 8'h11
`define ADCRW_IDX_WLT_L 8'h12
`define ADCRW_IDX_WLT_H 8'h13
`define ADCRW_IDX_WHT_L 8'h14
`define ADCRW_IDX_WHT_H 8'h15
`define ADCRW_IDX_CAL 8'h16
`define ADCRW_RST_BYTE 8'h00
`define ADCRW_RST_WORD 16'h0000
`define ADCRW_RST_CAL 8'h01
`define ADCRW_CODE_MAX 10'h3ff
`define ADCRW_ACC_CEIL 16'hffc0
`define ADCRW_MAX_LOG2 3'h6
`define ADCRW_FLAG_RDY 0
`define ADCRW_FLAG_WIN 1
`define ADCRW_DUTY_BIT 0
`define ADCRW_MODE_MSB 2
`define ADCRW_ACC_LSB 4
`define ADCRW_ACC_MSB 6
`endif

/* verilog/adcrw_pkg.sv */
// Types shared by the converter result block.
package adcrw_pkg;
   typedef enum logic [2:0] {
      ADCRW_WIN_NONE = 3'h0,
      ADCRW_WIN_BELOW = 3'h1,
      ADCRW_WIN_ABOVE = 3'h2,
      ADCRW_WIN_INSIDE = 3'h3,
      ADCRW_WIN_OUTSIDE = 3'h4
   } adcrw_mode_t;
   typedef enum logic [1:0] {
      ADCRW_ST_IDLE = 2'b01,
      ADCRW_ST_READ = 2'b10
   } adcrw_state_t;
endpackage

/* verilog/adcrw_win_if.sv */
// Interface between the register file and the window comparator.
`timescale 1ns/1ps
interface adcrw_win_if;
   logic clk;
   logic rst_b;
   logic [15:0] value;
   logic [15:0] low;
   logic [15:0] high;
   adcrw_pkg::adcrw_mode_t mode;
   logic match;
   modport regs (output clk, output rst_b, output value, output low, output high,
                 output mode, input match);
   modport cmp (input clk, input rst_b, input value, input low, input high,
                input mode, output match);
endinterface

/* verilog/adcrw_window.sv */
// Window comparator on the accumulated conversion value.
`timescale 1ns/1ps
module adcrw_window (
   // Comparator side.
   adcrw_win_if.cmp win
);
   wire below = win.value < win.low;
   wire above = win.value > win.high;

   assign win.match = (win.mode == adcrw_pkg::ADCRW_WIN_BELOW) ? below :
                      (win.mode == adcrw_pkg::ADCRW_WIN_ABOVE) ? above :
                      (win.mode == adcrw_pkg::ADCRW_WIN_INSIDE) ?
                         (win.value > win.low) && (win.value < win.high) :
                      (win.mode == adcrw_pkg::ADCRW_WIN_OUTSIDE) ? (below || above) :
                      1'b0;

   chk_inside_strict: assert property (@(posedge win.clk) disable iff (!win.rst_b)
      (win.mode == adcrw_pkg::ADCRW_WIN_INSIDE && win.value == win.low) |-> !win.match)
      else $error("Inside mode matched on the low threshold itself.");
   chk_none_silent: assert property (@(posedge win.clk) disable iff (!win.rst_b)
      (win.mode == adcrw_pkg::ADCRW_WIN_NONE || win.mode > adcrw_pkg::ADCRW_WIN_OUTSIDE)
      |-> !win.match)
      else $error("Window matched with comparison disabled or reserved.");
   chk_unsigned_above: assert property (@(posedge win.clk) disable iff (!win.rst_b)
      (win.mode == adcrw_pkg::ADCRW_WIN_ABOVE && win.value[15] && !win.high[15])
      |-> win.match)
      else $error("Above mode did not use unsigned ordering.");
endmodule

/* tb/adc_result_window_regs_tb.sv */
// Self-checking bench for the converter result register block.
`timescale 1ns/1ps
module adc_result_window_regs_tb;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic sample_valid = 1'b0;
   logic signed [11:0] sample_raw = 12'h000;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic adc_clk;
   logic irq;
   logic [31:0] rd;
   logic [15:0] lo_t;
   logic [15:0] hi_t;
   logic [7:0] v8;
   int bad_count = 0;
   int checked = 0;

   always #25 clk_sys = ~clk_sys;

   adcrw_regs dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_valid(sample_valid),
      .sample_raw(sample_raw), .adc_clk(adc_clk), .irq(irq));

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // The slave may stretch a phase; a stuck bus ends the run rather than hanging it.
   task automatic wait_rdy;
      int i;
      i = 0;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) begin
         i++;
         if (i > 16) begin
            bad_count++;
            tally_and_finish();
         end
         @(posedge clk_sys);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {22'h0, idx, 2'h0};
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      wait_rdy();
      rd = hrdata;
   endtask

   function automatic logic [9:0] sat(input logic signed [11:0] v);
      if (v < 0) return 10'h000;
      if (v > 12'sd1023) return 10'h3ff;
      return v[9:0];
   endfunction

   function automatic logic win(input logic [2:0] m, input logic [15:0] r);
      case (m)
         3'h1: return r < lo_t;
         3'h2: return r > hi_t;
         3'h3: return (r > lo_t) && (r < hi_t);
         3'h4: return (r < lo_t) || (r > hi_t);
         default: return 1'b0;
      endcase
   endfunction

   task automatic conv(input logic [2:0] n, input logic [2:0] m, input logic [7:0] msk,
                       input logic big);
      logic [15:0] sum;
      logic signed [11:0] v;
      logic w;
      int k;
      sum = 16'h0;
      bus(1'b1, 8'h0a, msk);
      bus(1'b1, 8'h04, {1'b0, n, 1'b0, m});
      for (k = 0; k < (1 << n); k++) begin
         v = big ? 12'sd2047 : 12'($urandom_range(1150)) - 12'sd60;
         sum = sum + 16'(sat(v));
         sample_valid <= 1'b1;
         sample_raw <= v;
         @(posedge clk_sys);
         sample_valid <= 1'b0;
         @(posedge clk_sys);
      end
      w = win(m, sum);
      repeat (2) @(posedge clk_sys);
      cmp_bit(irq, |({w, 1'b1} & msk[1:0]));
      bus(1'b0, 8'h0b, 8'h00);
      cmp_word(rd, {30'h0, w, 1'b1});
      if (msk != 8'h00) begin
         bus(1'b1, 8'h0b, 8'h00);
         bus(1'b1, 8'h0b, 8'h01);
         bus(1'b0, 8'h0b, 8'h00);
         cmp_word(rd, {30'h0, w, 1'b0});
         bus(1'b1, 8'h0b, 8'h02);
      end
      bus(1'b0, 8'h10, 8'h00);
      cmp_word(rd, {24'h0, sum[7:0]});
      bus(1'b0, 8'h11, 8'h00);
      cmp_word(rd, {24'h0, sum[15:8]});
      bus(1'b0, 8'h0b, 8'h00);
      cmp_word(rd, 32'h0);
      cmp_bit(irq, 1'b0);
      $display("conversion test mode %0d samples %0d done", m, 1 << n);
   endtask

   task automatic duty(input int exp);
      int cnt;
      cnt = 0;
      // A new duty setting reaches the clock one cycle after the write lands.
      @(posedge clk_sys);
      repeat (8) begin
         @(posedge clk_sys);
         cnt += int'(adc_clk);
      end
      cmp_word(32'(cnt), 32'(exp));
   endtask

   initial begin
      int k;
      void'($urandom(78414));
      repeat (6) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (k = 0; k < 8; k++) begin
         bus(1'b0, (k == 0) ? 8'h0d : 8'(8'h0f + k), 8'h00);
         cmp_word(rd, (k == 7) ? 32'h1 : 32'h0);
      end
      $display("reset value test done");
      v8 = 8'($urandom);
      bus(1'b1, 8'h0d, v8);
      bus(1'b0, 8'h0d, 8'h00);
      cmp_word(rd, {24'h0, v8});
      bus(1'b0, 8'h13, 8'h00);
      cmp_word(rd, {24'h0, v8});
      $display("byte latch test done");
      repeat (3) begin
         lo_t = 16'($urandom);
         hi_t = 16'($urandom);
         bus(1'b1, 8'h12, lo_t[7:0]);
         bus(1'b1, 8'h13, lo_t[15:8]);
         bus(1'b1, 8'h14, hi_t[7:0]);
         bus(1'b1, 8'h15, hi_t[15:8]);
         bus(1'b0, 8'h12, 8'h00);
         bus(1'b0, 8'h14, 8'h00);
         cmp_word(rd, {24'h0, hi_t[7:0]});
         bus(1'b0, 8'h15, 8'h00);
         cmp_word(rd, {24'h0, hi_t[15:8]});
         bus(1'b0, 8'h12, 8'h00);
         cmp_word(rd, {24'h0, lo_t[7:0]});
         bus(1'b0, 8'h13, 8'h00);
         cmp_word(rd, {24'h0, lo_t[15:8]});
      end
      bus(1'b1, 8'h10, 8'hff);
      bus(1'b0, 8'h10, 8'h00);
      cmp_word(rd, 32'h0);
      cmp_bit(hresp, 1'b0);
      bus(1'b0, 8'h3f, 8'h00);
      cmp_word(rd, 32'h0);
      $display("threshold and access test done");
      // Thresholds sit inside the single-sample span so below, above, inside and outside modes can each see both outcomes.
      lo_t = 16'h0100;
      hi_t = 16'h0300;
      bus(1'b1, 8'h12, 8'h00);
      bus(1'b1, 8'h13, 8'h01);
      bus(1'b1, 8'h14, 8'h00);
      bus(1'b1, 8'h15, 8'h03);
      for (k = 0; k < 6; k++) begin
         conv(3'($urandom_range(2)), 3'(k), 8'h03, 1'b0);
      end
      conv(3'h6, 3'h4, 8'h00, 1'b1);
      duty(2);
      bus(1'b1, 8'h16, 8'h00);
      duty(4);
      rst_b <= 1'b0;
      @(posedge clk_sys);
      rst_b <= 1'b1;
      bus(1'b0, 8'h16, 8'h00);
      cmp_word(rd, 32'h1);
      $display("clock duty test done");
      tally_and_finish();
   end
endmodule
